// ===== shared/uart_pin_pkg.sv
// Constants for the serial line and modem handshake pin logic of one channel.
// Assumes a 32-bit AXI4-Lite register port; registers are eight bits wide in the low byte.
package uart_pin_pkg;
  // Register width and byte offsets on the register bus.
  localparam int REG_W = 8;
  localparam logic [7:0] ADDR_MODEM_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODEM_STAT = 8'h04;
  localparam logic [7:0] ADDR_FLOW_CTRL = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  //////////////////////////////////////////////////////////////////////////////
  // Field positions in the modem control register.
  localparam int MC_TERM_READY = 0;
  localparam int MC_REQ_SEND = 1;
  localparam int MC_LOOP = 4;
  localparam int MC_INFRARED = 6;
  // Field positions in the modem status register.
  localparam int MS_DELTA_CTS = 0;
  localparam int MS_DELTA_DSR = 1;
  localparam int MS_CTS = 4;
  localparam int MS_DSR = 5;
  // Field positions in the flow control register.
  localparam int FC_AUTO_RTS = 0;
  localparam int FC_AUTO_CTS = 1;
  // Field position of the modem event in the interrupt status and mask registers.
  localparam int IRQ_MODEM = 0;
  //////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
  localparam logic [7:0] FLOW_CTRL_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic PIN_IDLE_HIGH = 1'b1;
  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Synchroniser depth for pin inputs.
  localparam int SYNC_STAGES = 2;
endpackage : uart_pin_pkg

// ===== hdl/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes each bit is an independent level; no multi-bit coherence is given.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic RST_LEVEL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  initial begin
    if (WIDTH < 1) begin
      $error("pin_sync needs at least one bit");
    end
  end

  // The first stage feeds only the second, so metastability cannot reach logic.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q <= {WIDTH{RST_LEVEL}};
      stable_q <= {WIDTH{RST_LEVEL}};
    end else if (ce) begin
      meta_q <= pin_async;
      stable_q <= meta_q;
    end
  end

  assign pin_sync_out = stable_q;
endmodule : pin_sync

// ===== hdl/uart_modem_pins.sv
// Serial line and modem handshake pin logic of one UART channel, with an AXI4-Lite register port.
// Assumes the transmitter, receiver and receive FIFO run on clk_sys and drive their side directly.
//
// Summary of operation
// - Without infrared mode the transmit output rests high after reset and when idle.
// - With infrared mode the transmit output rests low.
// - Reset always comes up in ordinary asynchronous mode, never infrared.
// - Setting the request-to-send bit drives the active-low request output low.
// - Automatic flow control drives request-to-send from receive fill versus trigger level.
// - Request-to-send output is high after reset and while idle.
// - Loop mode forces request-to-send output inactive high.
// - Setting the terminal-ready bit drives the active-low terminal-ready output low.
// - Terminal-ready output is high after reset and while idle.
// - Loop mode holds terminal-ready output inactive high.
// - Clear-to-send status bit reads as inverse of its input pin, or as the request-to-send bit in loop mode.
// - Clear-to-send delta bit sets on any change since last status read.
// - Automatic flow control lets transmission proceed only while clear-to-send is active.
// - Data-set-ready status bit reads as inverse of its input pin, or as the terminal-ready bit in loop mode.
// - Data-set-ready delta bit sets on any change since last status read.
// - Each change of either mirrored bit raises the modem interrupt when enabled.
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/10ps
module uart_modem_pins #(
  parameter int ADDR_W = 8,
  parameter int FILL_W = 7
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // AXI4-Lite slave.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Transmitter and receiver side on clk_sys.
  input wire logic tx_active,
  input wire logic tx_bit,
  output logic tx_permit,
  output logic rx_line,
  input wire logic [FILL_W-1:0] rx_fill,
  input wire logic [FILL_W-1:0] rx_trigger,
  // Pins.
  output logic tx_serial_out,
  input wire logic rx_serial_in,
  output logic rts_n,
  output logic dtr_n,
  input wire logic cts_n,
  input wire logic dsr_n,
  output logic irq
);
  logic [7:0] modem_ctrl_q;
  logic [7:0] fcr_q;
  logic [7:0] mask_q;
  logic istat_q;
  logic dcts_q;
  logic ddsr_q;
  logic cts_prev_q;
  logic dsr_prev_q;
  logic tx_q;
  logic rts_n_q;
  logic dtr_n_q;
  logic rx_line_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [2:0] pins_s;
  logic rx_s;
  logic cts_act;
  logic dsr_act;
  logic modem_change;
  logic wr_go;
  logic rd_go;
  logic wr_lane0;
  logic modem_stat_read;
  logic [7:0] modem_stat_val;
  logic [7:0] rd_val;

  initial begin
    if (ADDR_W < 8 || FILL_W < 1) begin
      $error("uart_modem_pins: ADDR_W must be at least 8 and FILL_W at least 1");
    end
  end

  // Tells whether a byte address hits one of the channel registers.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = a[7:0];
    reg_hit = (a[1:0] == 2'h0) && (a[ADDR_W-1:5] == '0) &&
      (b == uart_pin_pkg::ADDR_MODEM_CTRL || b == uart_pin_pkg::ADDR_MODEM_STAT ||
       b == uart_pin_pkg::ADDR_FLOW_CTRL || b == uart_pin_pkg::ADDR_IRQ_STAT ||
       b == uart_pin_pkg::ADDR_IRQ_MASK);
  endfunction : reg_hit

  //////////////////////////////////////////////////////////////////////////////
  // Pin inputs cross into clk_sys; the idle level is high so reset looks like an idle line.
  pin_sync #(
    .WIDTH(3),
    .RST_LEVEL(uart_pin_pkg::PIN_IDLE_HIGH)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .pin_async({rx_serial_in, dsr_n, cts_n}),
    .pin_sync_out(pins_s)
  );
  assign rx_s = pins_s[2];

  // In loop mode the handshake outputs are fed back internally instead of the pins.
  assign cts_act = modem_ctrl_q[uart_pin_pkg::MC_LOOP] ? modem_ctrl_q[uart_pin_pkg::MC_REQ_SEND] :
    ~pins_s[0];
  assign dsr_act = modem_ctrl_q[uart_pin_pkg::MC_LOOP] ? modem_ctrl_q[uart_pin_pkg::MC_TERM_READY] :
    ~pins_s[1];
  assign modem_change = (cts_act != cts_prev_q) || (dsr_act != dsr_prev_q);

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one write and one read in flight; address and data are taken together.
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign rd_go = s_axi_arvalid && !rvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign wr_lane0 = wr_go && reg_hit(s_axi_awaddr) && s_axi_wstrb[0];
  assign modem_stat_read = rd_go && (s_axi_araddr[7:0] == uart_pin_pkg::ADDR_MODEM_STAT) && reg_hit(s_axi_araddr);

  // Write response one cycle after acceptance; unmapped addresses answer SLVERR.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q <= uart_pin_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= reg_hit(s_axi_awaddr) ? uart_pin_pkg::RESP_OKAY : uart_pin_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read data is captured at acceptance so it stays stable while rready is low.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rresp_q <= uart_pin_pkg::RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else if (ce) begin
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= reg_hit(s_axi_araddr) ? uart_pin_pkg::RESP_OKAY : uart_pin_pkg::RESP_SLVERR;
        rdata_q <= {24'h000000, reg_hit(s_axi_araddr) ? rd_val : 8'h00};
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Modem status view; the current levels are shown live, the deltas from flops.
  always_comb begin
    modem_stat_val = 8'h00;
    modem_stat_val[uart_pin_pkg::MS_DELTA_CTS] = dcts_q;
    modem_stat_val[uart_pin_pkg::MS_DELTA_DSR] = ddsr_q;
    modem_stat_val[uart_pin_pkg::MS_CTS] = cts_act;
    modem_stat_val[uart_pin_pkg::MS_DSR] = dsr_act;
  end

  // Read multiplexer over the low address byte.
  always_comb begin
    case (s_axi_araddr[7:0])
      uart_pin_pkg::ADDR_MODEM_CTRL: rd_val = modem_ctrl_q;
      uart_pin_pkg::ADDR_MODEM_STAT: rd_val = modem_stat_val;
      uart_pin_pkg::ADDR_FLOW_CTRL: rd_val = fcr_q;
      uart_pin_pkg::ADDR_IRQ_STAT: rd_val = {7'h00, istat_q};
      uart_pin_pkg::ADDR_IRQ_MASK: rd_val = mask_q;
      default: rd_val = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control registers; reset clears the infrared bit so a channel never wakes up in infrared.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      modem_ctrl_q <= uart_pin_pkg::MODEM_CTRL_RST;
      fcr_q <= uart_pin_pkg::FLOW_CTRL_RST;
      mask_q <= uart_pin_pkg::IRQ_MASK_RST;
    end else if (ce && wr_lane0) begin
      case (s_axi_awaddr[7:0])
        uart_pin_pkg::ADDR_MODEM_CTRL: modem_ctrl_q <= s_axi_wdata[7:0];
        uart_pin_pkg::ADDR_FLOW_CTRL: fcr_q <= s_axi_wdata[7:0];
        uart_pin_pkg::ADDR_IRQ_MASK: mask_q <= s_axi_wdata[7:0];
        default: modem_ctrl_q <= modem_ctrl_q;
      endcase
    end
  end

  // Change tracking; a change in the same cycle as a status read survives the read.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cts_prev_q <= 1'b0;
      dsr_prev_q <= 1'b0;
      dcts_q <= 1'b0;
      ddsr_q <= 1'b0;
    end else if (ce) begin
      cts_prev_q <= cts_act;
      dsr_prev_q <= dsr_act;
      dcts_q <= (cts_act != cts_prev_q) || (dcts_q && !modem_stat_read);
      ddsr_q <= (dsr_act != dsr_prev_q) || (ddsr_q && !modem_stat_read);
    end
  end

  // Sticky modem event: cleared by writing one or by a status read, but a new change wins.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      istat_q <= 1'b0;
    end else if (ce) begin
      if (modem_change) begin
        istat_q <= 1'b1;
      end else if (modem_stat_read) begin
        istat_q <= 1'b0;
      end else if (wr_lane0 && s_axi_awaddr[7:0] == uart_pin_pkg::ADDR_IRQ_STAT &&
                   s_axi_wdata[uart_pin_pkg::IRQ_MODEM]) begin
        istat_q <= 1'b0;
      end
    end
  end

  assign irq = istat_q && mask_q[uart_pin_pkg::IRQ_MODEM];

  //////////////////////////////////////////////////////////////////////////////
  // Handshake pin outputs are registered so they never glitch; loop mode parks the handshakes high.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rts_n_q <= uart_pin_pkg::PIN_IDLE_HIGH;
      dtr_n_q <= uart_pin_pkg::PIN_IDLE_HIGH;
    end else if (ce) begin
      if (modem_ctrl_q[uart_pin_pkg::MC_LOOP]) begin
        rts_n_q <= 1'b1;
        dtr_n_q <= 1'b1;
      end else begin
        if (fcr_q[uart_pin_pkg::FC_AUTO_RTS]) begin
          rts_n_q <= (rx_fill >= rx_trigger);
        end else begin
          rts_n_q <= ~modem_ctrl_q[uart_pin_pkg::MC_REQ_SEND];
        end
        dtr_n_q <= ~modem_ctrl_q[uart_pin_pkg::MC_TERM_READY];
      end
    end
  end

  // Transmit line: the idle level follows the mode; infrared pulses high for each zero bit.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_q <= uart_pin_pkg::PIN_IDLE_HIGH;
    end else if (ce) begin
      if (modem_ctrl_q[uart_pin_pkg::MC_INFRARED]) begin
        tx_q <= tx_active && !tx_bit && !modem_ctrl_q[uart_pin_pkg::MC_LOOP];
      end else begin
        tx_q <= !(tx_active && !modem_ctrl_q[uart_pin_pkg::MC_LOOP]) || tx_bit;
      end
    end
  end

  // Receive line to the receiver; the pin's idle level is the partner's duty.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_line_q <= uart_pin_pkg::PIN_IDLE_HIGH;
    end else if (ce) begin
      if (modem_ctrl_q[uart_pin_pkg::MC_LOOP]) begin
        rx_line_q <= modem_ctrl_q[uart_pin_pkg::MC_INFRARED] ? (tx_active && !tx_bit) : (!tx_active || tx_bit);
      end else begin
        rx_line_q <= rx_s;
      end
    end
  end

  assign tx_serial_out = tx_q;
  assign rts_n = rts_n_q;
  assign dtr_n = dtr_n_q;
  assign rx_line = rx_line_q;
  assign tx_permit = !fcr_q[uart_pin_pkg::FC_AUTO_CTS] || cts_act;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the pin and status behaviour.
  a_tx_idle_async: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && !modem_ctrl_q[uart_pin_pkg::MC_INFRARED] && !tx_active |=> tx_serial_out)
    else $error("transmit line not high while idle");
  a_tx_idle_infra: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && modem_ctrl_q[uart_pin_pkg::MC_INFRARED] && !tx_active |=> !tx_serial_out)
    else $error("transmit line not low while infrared idle");
  a_rts_loop_high: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && modem_ctrl_q[uart_pin_pkg::MC_LOOP] |=> rts_n && dtr_n)
    else $error("handshake outputs not parked in loop mode");
  a_rts_from_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && !modem_ctrl_q[uart_pin_pkg::MC_LOOP] && !fcr_q[uart_pin_pkg::FC_AUTO_RTS] |=>
    rts_n == !$past(modem_ctrl_q[uart_pin_pkg::MC_REQ_SEND]))
    else $error("request output does not follow its control bit");
  a_rts_auto_fill: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && !modem_ctrl_q[uart_pin_pkg::MC_LOOP] && fcr_q[uart_pin_pkg::FC_AUTO_RTS] && rx_fill < rx_trigger
    |=> !rts_n)
    else $error("automatic request output not asserted below trigger");
  a_dtr_from_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && !modem_ctrl_q[uart_pin_pkg::MC_LOOP] && modem_ctrl_q[uart_pin_pkg::MC_TERM_READY] |=> !dtr_n)
    else $error("terminal-ready output not driven low");
  // Checked against the raw pin two enabled edges back, so a broken synchroniser shows up.
  a_cts_mirror: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(ce) && $past(ce, 2) && $past(nrst, 2) && !modem_ctrl_q[uart_pin_pkg::MC_LOOP] |->
    modem_stat_val[uart_pin_pkg::MS_CTS] == !$past(cts_n, 2))
    else $error("clear-to-send status is not the inverted pin");
  a_dsr_delta_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && $past(ce) && $changed(dsr_act) |=> ddsr_q)
    else $error("data-set-ready delta not set after change");
  a_cts_delta_set: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && $past(ce) && $changed(cts_act) |=> dcts_q)
    else $error("clear-to-send delta not set after change");
  a_read_clears: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && modem_stat_read && !modem_change |=> !dcts_q && !ddsr_q && !istat_q)
    else $error("status read did not clear change indications");
  a_irq_on_change: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && modem_change && mask_q[uart_pin_pkg::IRQ_MODEM] ##1 !$changed(mask_q) |-> irq)
    else $error("modem change did not raise the interrupt");
  a_tx_permit: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(ce) && $past(ce, 2) && $past(nrst, 2) && fcr_q[uart_pin_pkg::FC_AUTO_CTS] &&
    !modem_ctrl_q[uart_pin_pkg::MC_LOOP] |-> tx_permit == !$past(cts_n, 2))
    else $error("transmit permit ignores clear-to-send");
  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!nrst)
    ce && wr_go |=> s_axi_bvalid)
    else $error("write response missing one cycle after acceptance");
endmodule : uart_modem_pins

// ===== test/link_partner.sv
// Model of the remote link partner: drives the handshake inputs and the receive line.
// Assumes the bench sets the wanted handshake levels and the line mode on clk_sys.
`timescale 1ns/10ps
module link_partner (
  input wire logic clk_sys,
  input wire logic ir_mode,
  input wire logic cts_on,
  input wire logic dsr_on,
  output logic cts_n,
  output logic dsr_n,
  output logic rx_serial_in
);
  // Handshakes follow the request one cycle late, as a slow remote would; active low on the wire.
  always_ff @(posedge clk_sys) begin
    cts_n <= ~cts_on;
    dsr_n <= ~dsr_on;
  end
  // The line rests high in asynchronous mode and low in infrared mode.
  assign rx_serial_in = ~ir_mode;
endmodule : link_partner

// ===== test/test_uart_modem_pins.sv
// Self-checking bench for the modem pin block: register tasks on AXI4-Lite, then pin checks.
// Assumes one 25 MHz clock and the link partner model beside the block.
`timescale 1ns/10ps
module test_uart_modem_pins;
  localparam logic [7:0] A_CTRL = uart_pin_pkg::ADDR_MODEM_CTRL;
  localparam logic [7:0] A_STAT = uart_pin_pkg::ADDR_MODEM_STAT;
  localparam logic [7:0] A_FLOW = uart_pin_pkg::ADDR_FLOW_CTRL;
  localparam logic [7:0] A_ISTAT = uart_pin_pkg::ADDR_IRQ_STAT;
  localparam logic [7:0] A_MASK = uart_pin_pkg::ADDR_IRQ_MASK;
  localparam logic [1:0] ERR = uart_pin_pkg::RESP_SLVERR;
  logic clk_sys, nrst, ce, tx_active, tx_bit, tx_permit, rx_line, tx_serial_out, rx_serial_in;
  logic rts_n, dtr_n, cts_n, dsr_n, irq, ir_mode, cts_on, dsr_on;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [6:0] rx_fill, rx_trigger;
  int err_total, tests_run;
  //////////////////////////////////////////////////////////////////////////////
  // Free-running 40 ns clock.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  uart_modem_pins dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_active(tx_active), .tx_bit(tx_bit), .tx_permit(tx_permit), .rx_line(rx_line),
    .rx_fill(rx_fill), .rx_trigger(rx_trigger), .tx_serial_out(tx_serial_out), .rx_serial_in(rx_serial_in),
    .rts_n(rts_n), .dtr_n(dtr_n), .cts_n(cts_n), .dsr_n(dsr_n), .irq(irq));
  link_partner partner (.clk_sys(clk_sys), .ir_mode(ir_mode), .cts_on(cts_on), .dsr_on(dsr_on),
    .cts_n(cts_n), .dsr_n(dsr_n), .rx_serial_in(rx_serial_in));
  //////////////////////////////////////////////////////////////////////////////
  // Compare and count; four-state equality so an unknown never matches.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // Let n edges pass, then step off the edge so outputs are settled.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic set_tx(input logic act, input logic b);
    @(posedge clk_sys);
    tx_active <= act;
    tx_bit <= b;
    tick(2);
  endtask : set_tx
  // Write: address and data offered together, each dropped at its own handshake edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    bit got;
    got = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
      end
    end
    check({31'h0, got}, 32'h1);
  endtask : wr
  // Read and compare data and response at the edge that takes rvalid.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    bit got;
    got = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !got; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        rready <= 1'b0;
        check(rdata, exp);
        check({30'h0, rresp}, {30'h0, er});
      end
    end
    check({31'h0, got}, 32'h1);
  endtask : rd
  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  //////////////////////////////////////////////////////////////////////////////
  // The whole run is a few hundred cycles; a hang is cut well beyond that.
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    stop_test();
  end
  // Main sequence of tests.
  initial begin
    {nrst, tx_active, tx_bit, ir_mode, cts_on, dsr_on} = 6'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    rx_fill = 7'h00;
    rx_trigger = 7'h08;
    ce = 1'b1;
    err_total = 0;
    tests_run = 0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    tick(2);
    check({tx_serial_out, rts_n, dtr_n, irq}, 4'hE);
    rd(A_CTRL, 32'h0);
    rd(A_FLOW, 32'h0);
    rd(A_MASK, 32'h0);
    wr(A_STAT, 32'hFF);
    rd(A_STAT, 32'h0);
    wr(8'h14, 32'h1, ERR);
    rd(8'h14, 32'h0, ERR);
    rd(8'h02, 32'h0, ERR);
    $display("test reset_and_map done");
    wr(A_CTRL, 32'h01);
    tick(2);
    check({rts_n, dtr_n}, 2'b10);
    wr(A_CTRL, 32'h02);
    tick(2);
    check({rts_n, dtr_n}, 2'b01);
    wr(A_CTRL, 32'h13);
    tick(4);
    check({rts_n, dtr_n, tx_serial_out}, 3'b111);
    rd(A_STAT, 32'h33);
    wr(A_CTRL, 32'h00);
    tick(4);
    rd(A_STAT, 32'h03);
    rd(A_STAT, 32'h00);
    $display("test control_and_loop done");
    set_tx(1'b1, 1'b0);
    check(tx_serial_out, 1'b0);
    wr(A_CTRL, 32'h40);
    set_tx(1'b0, 1'b0);
    check(tx_serial_out, 1'b0);
    set_tx(1'b1, 1'b0);
    check(tx_serial_out, 1'b1);
    set_tx(1'b0, 1'b0);
    ir_mode <= 1'b1;
    tick(4);
    check(rx_line, 1'b0);
    // A reset in mid-run while infrared is on must bring the line back to asynchronous idle.
    @(posedge clk_sys);
    nrst <= 1'b0;
    ir_mode <= 1'b0;
    tick(2);
    @(posedge clk_sys);
    nrst <= 1'b1;
    tick(2);
    check({tx_serial_out, rx_line}, 2'b11);
    rd(A_CTRL, 32'h0);
    $display("test line_levels done");
    wr(A_FLOW, 32'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      rx_fill <= 7'(7 + i);
      tick(2);
      check(rts_n, logic'(i != 0));
    end
    wr(A_FLOW, 32'h2);
    tick(4);
    check(tx_permit, 1'b0);
    cts_on <= 1'b1;
    tick(5);
    check(tx_permit, 1'b1);
    check(irq, 1'b0);
    rd(A_ISTAT, 32'h1);
    rd(A_STAT, 32'h11);
    rd(A_ISTAT, 32'h0);
    wr(A_FLOW, 32'h0);
    $display("test flow_control done");
    wr(A_MASK, 32'h1);
    dsr_on <= 1'b1;
    tick(6);
    check(irq, 1'b1);
    rd(A_STAT, 32'h32);
    tick(1);
    check(irq, 1'b0);
    cts_on <= 1'b0;
    tick(6);
    check(irq, 1'b1);
    wr(A_ISTAT, 32'h1);
    tick(1);
    check(irq, 1'b0);
    rd(A_STAT, 32'h21);
    rd(A_MASK, 32'h1);
    $display("test modem_interrupt done");
    // With the clock enable low even the synchronisers freeze, so a pin change stays unseen.
    @(posedge clk_sys);
    ce <= 1'b0;
    dsr_on <= 1'b0;
    tick(6);
    check(irq, 1'b0);
    @(posedge clk_sys);
    ce <= 1'b1;
    tick(6);
    check(irq, 1'b1);
    rd(A_STAT, 32'h02);
    $display("test clock_enable done");
    stop_test();
  end
endmodule : test_uart_modem_pins
